// file: verilog/sccr_pkg.sv
// sccr_pkg: constants for the serdes channel 2 configuration register bank
// assumes a 32-bit classic wishbone register bus with byte addresses
package sccr_pkg;

	//////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [7:0] SCCR_ADDR_CH2_CFG = 8'h00;
	localparam logic [7:0] SCCR_ADDR_GLOBAL = 8'h04;
	localparam logic [7:0] SCCR_ADDR_STATUS = 8'h08;

	//////////////////////////////////////////////////////////////////////
	// field positions of the channel register
	localparam int SCCR_POS_HALF_RATE = 0;
	localparam int SCCR_POS_TX_RECALC = 1;
	localparam int SCCR_POS_UNUSED_LO = 2;
	localparam int SCCR_POS_RSVD8 = 8;
	localparam int SCCR_POS_TX_EN = 9;
	localparam int SCCR_POS_TX_BOOST = 12;
	localparam int SCCR_POS_PLL_PWR = 16;
	localparam int SCCR_POS_RX_EN = 17;
	localparam int SCCR_POS_DPLL_RST = 18;
	localparam int SCCR_POS_RSVD19 = 19;
	localparam int SCCR_POS_RX_EQ = 21;
	localparam int SCCR_POS_DPLL_SEL = 24;
	localparam int SCCR_POS_TXCLK_PWR = 27;
	localparam int SCCR_POS_SIGNAL_LOSS_DETECTOR_CONTROL = 28;
	localparam int SCCR_POS_ALIGN_EN = 30;
	localparam int SCCR_POS_RSVD31 = 31;

	// position of the bypass-initialization bit in the global register
	localparam int SCCR_POS_BYPASS_INIT = 0;

	//////////////////////////////////////////////////////////////////////
	// reset value of the channel register; half rate has no defined reset,
	// it is held at zero here
	localparam logic [31:0] SCCR_RST_CH2_CFG = 32'hC8A7C610;
	localparam logic SCCR_RST_BYPASS_INIT = 1'h0;

	// field codes
	localparam logic [2:0] SCCR_TX_EN_OFF = 3'h0;
	localparam logic [2:0] SCCR_TX_EN_FULL = 3'h3;
	localparam logic [1:0] SCCR_LOS_OFF = 2'h0;
	localparam logic [1:0] SCCR_LOS_HEAVY = 2'h3;

	// mask of bits that are writable only under bypass-initialization
	localparam logic [31:0] SCCR_GATED_MASK = 32'h00030E00;
	// read-only reserved bit 8
	localparam logic [31:0] SCCR_RO_MASK = 32'h00000100;

endpackage : sccr_pkg

// file: verilog/sccr_edge_pulse.sv
// sccr_edge_pulse: one-cycle pulse on a 0-to-1 change of a stored bit
// assumes the bit and its previous value are on clk_i
module sccr_edge_pulse (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// level in
	input wire logic level_i,
	input wire logic rst_level_i,
	// pulse out
	output logic pulse_o
);
	import sccr_pkg::*;

	typedef struct packed {
		logic prev;
		logic pulse;
	} sccr_edge_state_type;

	sccr_edge_state_type state_ff;
	sccr_edge_state_type nxt_state;

	////////////////////////////////////////////////////////////////////////
	// compare new value with the stored one
	always_comb begin
		nxt_state = state_ff;
		nxt_state.prev = level_i;
		nxt_state.pulse = level_i & ~state_ff.prev;
	end

	// register state; prev takes the bit's own reset value to avoid a false pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff.prev <= rst_level_i;
			state_ff.pulse <= 1'h0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pulse_o = state_ff.pulse;
endmodule : sccr_edge_pulse

// file: verilog/sccr_rx_gate.sv
// sccr_rx_gate: effective receive enable, qualified by pll power and lock
// assumes the lock state input comes from the analog pll, another domain
module sccr_rx_gate (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// controls
	input wire logic rx_enable_i,
	input wire logic pll_power_i,
	input wire logic pll_lock_async_i,
	// effective enable and synchronised lock
	output logic rx_active_o,
	output logic pll_lock_o
);
	import sccr_pkg::*;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic active;
	} sccr_gate_state_type;

	sccr_gate_state_type state_ff;
	sccr_gate_state_type nxt_state;

	////////////////////////////////////////////////////////////////////////
	// two-stage synchroniser, then qualify the enable
	always_comb begin
		nxt_state = state_ff;
		nxt_state.sync1 = pll_lock_async_i;
		nxt_state.sync2 = state_ff.sync1;
		nxt_state.active = rx_enable_i & pll_power_i & state_ff.sync2;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rx_active_o = state_ff.active;
	assign pll_lock_o = state_ff.sync2;
endmodule : sccr_rx_gate

// file: verilog/sccr_regs.sv
// sccr_regs: serdes channel 2 configuration register bank
// assumes a classic wishbone master on clk_i and an analog transceiver on the outputs
//
// Contract
// - transmit boost in bits 12..15, reset 0xC, zero means no boost
// - bit 16 is receive pll power, 1 on, resets to 1
// - pll power, receive enable, transmit enable read-only unless bypass-init is 1
// - receive enable bit 17 gates rx outputs only with pll power and lock
// - rising edge of bit 18 resets the dpll frequency register; resets 1
// - receive equalization bits 21..23, reset 0x5, boost (value+1) half-dB
// - bit 27 powers transmit clock, resets 1, software keeps it 1
// - loss-of-signal control bits 28..29 reset 0; 00 off, 11 heavy filter
// - bit 30 enables word alignment, resets 1; cleared during prbs tests
// - bit 0 selects half baud rate; software changes it with speed setting
// - rising edge of bit 1 triggers transmit attenuation and boost recalculation
// - transmit enable bits 9..11 reset 0x3; 000 off, 011 fully on
//
// The implementer's own choices: the address map and the Wishbone register port.
module sccr_regs (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// transceiver status
	input wire logic pll_lock_i,
	// transceiver controls
	output logic half_rate_o,
	output logic tx_recalc_pulse_o,
	output logic [2:0] tx_enable_o,
	output logic [3:0] tx_boost_o,
	output logic tx_boost_on_o,
	output logic rx_pll_power_o,
	output logic rx_active_o,
	output logic dpll_frequency_reset_o,
	output logic [2:0] receive_equalization_o,
	output logic [2:0] receive_dpll_select_o,
	output logic transmit_clock_power_o,
	output logic los_detect_on_o,
	output logic los_heavy_filter_o,
	output logic word_align_en_o
);
	import sccr_pkg::*;

	typedef struct packed {
		logic [31:0] cfg;
		logic bypass;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} sccr_state_type;

	sccr_state_type state_ff;
	sccr_state_type nxt_state;
	logic rx_active;
	logic lock_sync;

	// byte-lane merge of write data into a stored word
	function automatic logic [31:0] sccr_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : sccr_merge

	////////////////////////////////////////////////////////////////////////
	// bus decode and register update
	always_comb begin
		logic req;
		logic [31:0] merged;
		logic [31:0] keep;
		req = 1'h0;
		merged = '0;
		keep = '0;
		nxt_state = state_ff;
		nxt_state.ack = 1'h0;
		nxt_state.err = 1'h0;
		req = wb_cyc_i & wb_stb_i & ~state_ff.ack & ~state_ff.err;
		if (req) begin
			unique case (wb_adr_i)
				SCCR_ADDR_CH2_CFG: begin
					nxt_state.ack = 1'h1;
					nxt_state.rdata = state_ff.cfg;
					if (wb_we_i) begin
						merged = sccr_merge(state_ff.cfg, wb_dat_i, wb_sel_i);
						// read-only bits, and gated bits while bypass is 0, keep their old value
						keep = SCCR_RO_MASK | (state_ff.bypass ? 32'h0 : SCCR_GATED_MASK);
						nxt_state.cfg = (merged & ~keep) | (state_ff.cfg & keep);
					end
				end
				SCCR_ADDR_GLOBAL: begin
					nxt_state.ack = 1'h1;
					nxt_state.rdata = '0;
					nxt_state.rdata[SCCR_POS_BYPASS_INIT] = state_ff.bypass;
					if (wb_we_i && wb_sel_i[0]) begin
						nxt_state.bypass = wb_dat_i[SCCR_POS_BYPASS_INIT];
					end
				end
				SCCR_ADDR_STATUS: begin
					nxt_state.ack = 1'h1;
					nxt_state.rdata = {30'h0, rx_active, lock_sync};
				end
				default: begin
					nxt_state.err = 1'h1; // unmapped address
					nxt_state.rdata = '0;
				end
			endcase
		end
	end

	// register state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff.cfg <= SCCR_RST_CH2_CFG;
			state_ff.bypass <= SCCR_RST_BYPASS_INIT;
			state_ff.ack <= 1'h0;
			state_ff.err <= 1'h0;
			state_ff.rdata <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign wb_ack_o = state_ff.ack;
	assign wb_err_o = state_ff.err;
	assign wb_dat_o = state_ff.rdata;

	////////////////////////////////////////////////////////////////////////
	// edge pulses for recalculation and dpll_frequency_reset
	sccr_edge_pulse u_recalc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(state_ff.cfg[SCCR_POS_TX_RECALC]),
		.rst_level_i(1'h0),
		.pulse_o(tx_recalc_pulse_o)
	);

	sccr_edge_pulse u_dpll_rst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(state_ff.cfg[SCCR_POS_DPLL_RST]),
		.rst_level_i(1'h1),
		.pulse_o(dpll_frequency_reset_o)
	);

	// receive enable qualified by pll power and lock
	sccr_rx_gate u_rx_gate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rx_enable_i(state_ff.cfg[SCCR_POS_RX_EN]),
		.pll_power_i(state_ff.cfg[SCCR_POS_PLL_PWR]),
		.pll_lock_async_i(pll_lock_i),
		.rx_active_o(rx_active),
		.pll_lock_o(lock_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// field outputs
	assign half_rate_o = state_ff.cfg[SCCR_POS_HALF_RATE];
	assign tx_enable_o = state_ff.cfg[SCCR_POS_TX_EN +: 3];
	assign tx_boost_o = state_ff.cfg[SCCR_POS_TX_BOOST +: 4];
	assign tx_boost_on_o = (state_ff.cfg[SCCR_POS_TX_BOOST +: 4] != 4'h0);
	assign rx_pll_power_o = state_ff.cfg[SCCR_POS_PLL_PWR];
	assign rx_active_o = rx_active;
	assign receive_equalization_o = state_ff.cfg[SCCR_POS_RX_EQ +: 3];
	assign receive_dpll_select_o = state_ff.cfg[SCCR_POS_DPLL_SEL +: 3];
	assign transmit_clock_power_o = state_ff.cfg[SCCR_POS_TXCLK_PWR];
	assign los_detect_on_o = (state_ff.cfg[SCCR_POS_SIGNAL_LOSS_DETECTOR_CONTROL +: 2] != SCCR_LOS_OFF);
	assign los_heavy_filter_o = (state_ff.cfg[SCCR_POS_SIGNAL_LOSS_DETECTOR_CONTROL +: 2] == SCCR_LOS_HEAVY);
	assign word_align_en_o = state_ff.cfg[SCCR_POS_ALIGN_EN];
endmodule : sccr_regs

// file: test/sccr_regs_asserts.sv
// sccr_regs_asserts: port-level property checks for the channel register bank
// assumes one clock domain and a synchronous active high reset
module sccr_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// transceiver side
	input wire logic pll_lock_i,
	input wire logic tx_recalc_pulse_o,
	input wire logic [2:0] tx_enable_o,
	input wire logic [3:0] tx_boost_o,
	input wire logic tx_boost_on_o,
	input wire logic rx_pll_power_o,
	input wire logic rx_active_o,
	input wire logic dpll_frequency_reset_o,
	input wire logic los_detect_on_o,
	input wire logic los_heavy_filter_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	//////////////////////////////////////////////////////////////////////
	// properties
	property p_boost_on; tx_boost_on_o == (tx_boost_o != 4'h0); endproperty
	a_boost_on: assert property (p_boost_on) else $error("boost flag wrong");
	property p_los; los_heavy_filter_o |-> los_detect_on_o; endproperty
	a_los: assert property (p_los) else $error("heavy filter without detector");
	property p_rx_pwr; rx_active_o |-> rx_pll_power_o; endproperty
	a_rx_pwr: assert property (p_rx_pwr) else $error("rx active without pll power");
	property p_rx_lock; !pll_lock_i [*4] |-> !rx_active_o; endproperty
	a_rx_lock: assert property (p_rx_lock) else $error("rx active without lock");
	property p_recalc_one; tx_recalc_pulse_o |=> !tx_recalc_pulse_o; endproperty
	a_recalc_one: assert property (p_recalc_one) else $error("recalc pulse too long");
	property p_dpll_one; dpll_frequency_reset_o |=> !dpll_frequency_reset_o; endproperty
	a_dpll_one: assert property (p_dpll_one) else $error("dpll pulse too long");
	property p_recalc_cause;
		tx_recalc_pulse_o |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
	endproperty
	a_recalc_cause: assert property (p_recalc_cause) else $error("recalc without write");
	property p_txen_write; $changed(tx_enable_o) |-> wb_ack_o && $past(wb_we_i); endproperty
	a_txen_write: assert property (p_txen_write) else $error("tx enable moved alone");
	property p_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer missing");
	// main scenarios
	c_recalc: cover property (tx_recalc_pulse_o);
	c_dpll: cover property (dpll_frequency_reset_o);
	c_rx: cover property (rx_active_o);
endmodule : sccr_chk

bind sccr_regs sccr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.pll_lock_i(pll_lock_i), .tx_recalc_pulse_o(tx_recalc_pulse_o), .tx_enable_o(tx_enable_o),
	.tx_boost_o(tx_boost_o), .tx_boost_on_o(tx_boost_on_o), .rx_pll_power_o(rx_pll_power_o),
	.rx_active_o(rx_active_o), .dpll_frequency_reset_o(dpll_frequency_reset_o),
	.los_detect_on_o(los_detect_on_o), .los_heavy_filter_o(los_heavy_filter_o));

// file: test/sccr_tb.sv
// testbench: self-checking bench for the channel 2 configuration register bank
// assumes the bank answers each wishbone request one cycle after taking it
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sccr_pkg::*;
	// reset image built field by field, gated bits, bits software always holds at 1
	localparam logic [31:0] CFG_RST = {4'hC, 1'b1, 3'h0, 3'h5, 2'h0, 3'h7, 4'hC, 3'h3, 1'b0, 6'h04, 2'h0};
	localparam logic [31:0] GATED = 32'h00030E00;
	localparam logic [31:0] KEEP = 32'h88000000;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, wen = 1'b0, lock = 1'b0, e;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, q, rdata;
	logic ack, err, half, recalc, boost_on, pll_pwr, rx_act, dpll, clk_pwr, los_on, heavy, align;
	logic [2:0] tx_en, eq, dsel;
	logic [3:0] boost;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	sccr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdata), .wb_ack_o(ack),
		.wb_err_o(err), .pll_lock_i(lock), .half_rate_o(half), .tx_recalc_pulse_o(recalc),
		.tx_enable_o(tx_en), .tx_boost_o(boost), .tx_boost_on_o(boost_on), .rx_pll_power_o(pll_pwr),
		.rx_active_o(rx_act), .dpll_frequency_reset_o(dpll), .receive_equalization_o(eq),
		.receive_dpll_select_o(dsel), .transmit_clock_power_o(clk_pwr), .los_detect_on_o(los_on),
		.los_heavy_filter_o(heavy), .word_align_en_o(align));
	//////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			complete_run();
		end
	end
	//////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle, held until ack or err is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, wen, adr, wdat} <= {1'b1, 1'b1, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
		q = rdata;
		e = err;
		{cyc, stb} <= 2'b00;
	endtask : bus
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : idle
	//////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		bus(1'b0, SCCR_ADDR_CH2_CFG, 32'h0);
		chk(q, CFG_RST);
		chk({boost, pll_pwr, eq, clk_pwr, los_on, align, tx_en}, {4'hC, 1'b1, 3'h5, 3'h5, 3'h3});
		chk({half, dsel, recalc, dpll}, 6'h00);
		bus(1'b0, 8'h0C, 32'h0);
		chk(e, 1'b1);
	endtask : t_reset
	task automatic t_gated();
		int nr, nd;
		bus(1'b1, SCCR_ADDR_CH2_CFG, KEEP);
		bus(1'b0, SCCR_ADDR_CH2_CFG, 32'h0);
		chk(q, KEEP | (CFG_RST & GATED));
		bus(1'b1, SCCR_ADDR_CH2_CFG, KEEP | 32'h00040102);
		nr = 0;
		nd = 0;
		// sample just after each edge, starting at the edge that returned the ack
		repeat (5) begin
			#1;
			nr += int'(recalc);
			nd += int'(dpll);
			@(posedge clk_i);
		end
		chk(nr, 1);
		chk(nd, 1);
		bus(1'b0, SCCR_ADDR_CH2_CFG, 32'h0);
		chk(q, KEEP | 32'h00040002 | (CFG_RST & GATED));
	endtask : t_gated
	task automatic t_bypass();
		bus(1'b1, SCCR_ADDR_GLOBAL, 32'h1);
		bus(1'b1, SCCR_ADDR_CH2_CFG, 32'hB8000000);
		bus(1'b0, SCCR_ADDR_CH2_CFG, 32'h0);
		chk(q, 32'hB8000000);
		idle(1);
		chk({tx_en, boost_on, pll_pwr, los_on, heavy, align, rx_act}, {3'h0, 6'h0C});
		@(posedge clk_i) lock <= 1'b1;
		bus(1'b1, SCCR_ADDR_CH2_CFG, 32'h88031600);
		idle(5);
		chk({rx_act, boost_on, tx_en}, {2'h3, 3'h3});
		@(posedge clk_i) lock <= 1'b0;
		idle(5);
		chk(rx_act, 1'b0);
		@(posedge clk_i) lock <= 1'b1;
		bus(1'b1, SCCR_ADDR_CH2_CFG, 32'h88020600);
		idle(5);
		chk(rx_act, 1'b0);
	endtask : t_bypass
	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_gated();
		t_bypass();
		complete_run();
	end
endmodule : testbench
